// file: logic/spimux_pkg.sv
/*
 Constants for the serial data pin multiplexer of the first serial port.
 Assumes one device clock domain and external pins seen through synchronisers.
*/
// How it works
// (RULE_01) Master samples the master-in line; slave drives it.
// (RULE_02) Unselected slave releases its master-in driver to high impedance.
// (RULE_03) Serial-assigned data pins are open-drain when wired-OR select is set.
// (RULE_04) Unused master-in function leaves the pin as port C bit zero.
// (RULE_05) After reset every data pin is an input with its driver off.
// (RULE_06) Master drives the master-out line; slave samples it.
// (RULE_07) Master presents each bit half a serial clock before the capture edge.
// (RULE_08) Unused master-out function leaves the pin as port C bit one.
// (RULE_09) Data shifts on one serial clock edge and samples on the other.
// (RULE_10) External master holds select low per transfer; our select high as master.
// (RULE_11) Slave selection uses the synchronised select level; drive only while low.
package spimux_pkg;
    localparam int SYNC_STAGES = 2;
    localparam logic PIN_OE_RESET = 1'h0;
    localparam logic PIN_OUT_RESET = 1'h0;
    localparam logic SELECT_RESET = 1'h1;
    localparam logic CLOCK_RESET = 1'h0;
    localparam logic DATA_RESET = 1'h0;
    localparam logic SHIFT_ON_FALL = 1'h1;
    localparam int MISO_BIT = 0;
    localparam int MOSI_BIT = 1;
endpackage

// file: logic/spimux_sync.sv
/*
 Two-flop level synchroniser with a constant reset value per bit.
 Assumes asynchronous inputs and an active-high asynchronous reset.
*/
`timescale 1ns/10ps
module spimux_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] firstStage;

    // First stage feeds only the second
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            firstStage <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end
        else
        begin
            firstStage <= asyncIn;
            syncOut <= firstStage;
        end
    end
endmodule

// file: logic/spimux_top.sv
/*
 Pin multiplexer for the two serial data lines of the first serial port.
 Assumes the serial core and port C logic share mclk; pins are asynchronous.
*/
`timescale 1ns/10ps
module spimux_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic misoFuncEnable,
    input wire logic mosiFuncEnable,
    input wire logic masterMode,
    input wire logic wiredOrSelect,
    input wire logic masterClock,
    input wire logic coreLoad,
    input wire logic coreTxBit,
    input wire logic [1:0] portCOut,
    input wire logic [1:0] portCDir,
    input wire logic port0MasterInSlaveOutIn,
    input wire logic port0MasterOutSlaveInIn,
    input wire logic port0SerialClockIn,
    input wire logic port0SlaveSelectN,
    output logic port0MasterInSlaveOutOut,
    output logic port0MasterInSlaveOutOe,
    output logic port0MasterOutSlaveInOut,
    output logic port0MasterOutSlaveInOe,
    output logic [1:0] portCIn,
    output logic coreRxBit,
    output logic coreRxStrobe,
    output logic coreTxTake,
    output logic slaveSelected
);
    typedef struct packed {
        logic misoOut;
        logic misoOe;
        logic mosiOut;
        logic mosiOe;
        logic clkPrev;
        logic txBit;
        logic rxBit;
        logic rxStrobe;
        logic txTake;
        logic selected;
        logic [1:0] gpioIn;
    } spimux_state_t;

    spimux_state_t state;
    spimux_state_t next_state;
    logic [3:0] pinsSync;
    logic misoSync;
    logic mosiSync;
    logic sclkSync;
    logic selectNSync;

    // Serial clock comes from the far master, so it is sampled like any pin
    spimux_sync #(
        .WIDTH(4),
        .RESET_VALUE({spimux_pkg::SELECT_RESET, spimux_pkg::CLOCK_RESET,
                      spimux_pkg::DATA_RESET, spimux_pkg::DATA_RESET})
    ) pinSync (
        .mclk(mclk),
        .rst(rst),
        .asyncIn({port0SlaveSelectN, port0SerialClockIn,
                  port0MasterOutSlaveInIn, port0MasterInSlaveOutIn}),
        .syncOut(pinsSync)
    );

    assign misoSync = pinsSync[0];
    assign mosiSync = pinsSync[1];
    assign sclkSync = pinsSync[2];
    assign selectNSync = pinsSync[3];

    // Open-drain only pulls low; a high bit releases the wire
    function automatic logic [1:0] driveBit(input logic bitValue, input logic openDrain);
        logic [1:0] result;
        result = 2'h0;
        if (openDrain)
        begin
            // Wired-OR pull-up restores the high level
            result = {1'h0, ~bitValue};
        end
        else
        begin
            result = {bitValue, 1'h1};
        end
        return result;
    endfunction

    always_comb
    begin
        logic activeClock;
        logic slaveSel;
        logic linkActive;
        logic shiftEdge;
        logic sampleEdge;
        logic fallEdge;
        logic riseEdge;
        logic [1:0] drive;
        activeClock = 1'h0;
        slaveSel = 1'h0;
        linkActive = 1'h0;
        shiftEdge = 1'h0;
        sampleEdge = 1'h0;
        fallEdge = 1'h0;
        riseEdge = 1'h0;
        drive = 2'h0;
        next_state = state;
        next_state.rxStrobe = 1'h0;
        next_state.txTake = 1'h0;
        // Core clock in master mode avoids two sync cycles of lag
        if (masterMode)
        begin
            activeClock = masterClock;
        end
        else
        begin
            activeClock = sclkSync;
        end
        // Synced select, so a pin glitch cannot half-drive the line
        slaveSel = !masterMode && !selectNSync; // RULE_11
        linkActive = masterMode || slaveSel; // RULE_10
        fallEdge = state.clkPrev && !activeClock;
        riseEdge = !state.clkPrev && activeClock;
        shiftEdge = spimux_pkg::SHIFT_ON_FALL ? fallEdge : riseEdge; // RULE_09
        sampleEdge = spimux_pkg::SHIFT_ON_FALL ? riseEdge : fallEdge; // RULE_09
        next_state.clkPrev = activeClock;
        next_state.selected = slaveSel;
        // Load wins so a fresh word never starts on a stale bit
        if (coreLoad)
        begin
            next_state.txBit = coreTxBit;
        end
        else if (shiftEdge && linkActive)
        begin
            // Bit lands half a serial period ahead of the capture edge
            next_state.txBit = coreTxBit; // RULE_07
            next_state.txTake = 1'h1;
        end
        if (sampleEdge && linkActive)
        begin
            if (masterMode)
            begin
                next_state.rxBit = misoSync; // RULE_01
            end
            else
            begin
                next_state.rxBit = mosiSync; // RULE_06
            end
            next_state.rxStrobe = 1'h1; // RULE_06
        end
        drive = 2'h0;
        if (misoFuncEnable)
        begin
            if (slaveSel)
            begin
                drive = driveBit(state.txBit, wiredOrSelect); // RULE_03
            end
            else
            begin
                drive = 2'h0; // RULE_02
            end
        end
        else
        begin
            drive = {portCOut[spimux_pkg::MISO_BIT], portCDir[spimux_pkg::MISO_BIT]}; // RULE_04
        end
        next_state.misoOut = drive[1];
        next_state.misoOe = drive[0];
        drive = 2'h0;
        if (mosiFuncEnable)
        begin
            if (masterMode)
            begin
                drive = driveBit(state.txBit, wiredOrSelect); // RULE_06
            end
            else
            begin
                // Slave only listens on this line
                drive = 2'h0; // RULE_06
            end
        end
        else
        begin
            drive = {portCOut[spimux_pkg::MOSI_BIT], portCDir[spimux_pkg::MOSI_BIT]}; // RULE_08
        end
        next_state.mosiOut = drive[1];
        next_state.mosiOe = drive[0];
        // Port C reads the pins even while the serial port owns them
        next_state.gpioIn = {mosiSync, misoSync};
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            // Drivers off and pins read as inputs
            state.misoOut <= spimux_pkg::PIN_OUT_RESET; // RULE_05
            state.misoOe <= spimux_pkg::PIN_OE_RESET; // RULE_05
            state.mosiOut <= spimux_pkg::PIN_OUT_RESET; // RULE_05
            state.mosiOe <= spimux_pkg::PIN_OE_RESET; // RULE_05
            state.clkPrev <= spimux_pkg::CLOCK_RESET;
            state.txBit <= spimux_pkg::DATA_RESET;
            state.rxBit <= spimux_pkg::DATA_RESET;
            state.rxStrobe <= 1'h0;
            state.txTake <= 1'h0;
            state.selected <= 1'h0;
            state.gpioIn <= 2'h0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign port0MasterInSlaveOutOut = state.misoOut;
    assign port0MasterInSlaveOutOe = state.misoOe;
    assign port0MasterOutSlaveInOut = state.mosiOut;
    assign port0MasterOutSlaveInOe = state.mosiOe;
    assign portCIn = state.gpioIn;
    assign coreRxBit = state.rxBit;
    assign coreRxStrobe = state.rxStrobe;
    assign coreTxTake = state.txTake;
    assign slaveSelected = state.selected;
endmodule

// file: tb/spimux_properties.sv
/*
 Port checker for the serial data pin multiplexer.
 Assumes binding to spimux_top and a single mclk domain.
*/
`timescale 1ns/10ps
module spimux_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire logic misoFuncEnable,
    input wire logic mosiFuncEnable,
    input wire logic masterMode,
    input wire logic wiredOrSelect,
    input wire logic masterClock,
    input wire logic coreLoad,
    input wire logic [1:0] portCOut,
    input wire logic [1:0] portCDir,
    input wire logic port0SlaveSelectN,
    input wire logic port0MasterInSlaveOutOut,
    input wire logic port0MasterInSlaveOutOe,
    input wire logic port0MasterOutSlaveInOut,
    input wire logic port0MasterOutSlaveInOe,
    input wire logic coreTxTake,
    input wire logic slaveSelected
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    unsel_hiz_a: assert property (
        (misoFuncEnable && !masterMode && port0SlaveSelectN) [*4] |-> !port0MasterInSlaveOutOe)
        else $error("miso driven while deselected");
    od_miso_a: assert property (
        $past(wiredOrSelect && misoFuncEnable) |-> !port0MasterInSlaveOutOut)
        else $error("miso drives high in open drain");
    od_mosi_a: assert property (
        $past(wiredOrSelect && mosiFuncEnable) |-> !port0MasterOutSlaveInOut)
        else $error("mosi drives high in open drain");
    gpio_miso_a: assert property ($past(!rst && !misoFuncEnable) |->
        port0MasterInSlaveOutOe == $past(portCDir[0])
        && (!port0MasterInSlaveOutOe || port0MasterInSlaveOutOut == $past(portCOut[0])))
        else $error("port c bit zero wrong");
    gpio_mosi_a: assert property ($past(!rst && !mosiFuncEnable) |->
        port0MasterOutSlaveInOe == $past(portCDir[1])
        && (!port0MasterOutSlaveInOe || port0MasterOutSlaveInOut == $past(portCOut[1])))
        else $error("port c bit one wrong");
    master_miso_a: assert property (
        $past(misoFuncEnable && masterMode) |-> !port0MasterInSlaveOutOe)
        else $error("master drives miso");
    slave_mosi_a: assert property (
        $past(mosiFuncEnable && !masterMode) |-> !port0MasterOutSlaveInOe)
        else $error("slave drives mosi");
    sel_sync_a: assert property (
        slaveSelected |-> $past(!port0SlaveSelectN, 3) && $past(!masterMode))
        else $error("selection without synced low select");
    shift_take_a: assert property (
        $past(masterMode) && masterMode && $fell(masterClock) && !coreLoad |-> ##[1:2] coreTxTake)
        else $error("no shift after clock fall");
endmodule
bind spimux_top spimux_properties i_spimux_properties (.*);

// file: tb/spimux_ext_master.sv
/*
 External serial master model driving select, clock and data.
 Assumes idle-low clock of 80 ns period; it stands still between frames.
*/
`timescale 1ns/10ps
module spimux_ext_master (
    output logic sck,
    output logic ssN,
    output logic mosi,
    input wire logic miso
);
    initial
    begin
        sck = 1'h0;
        ssN = 1'h1;
        mosi = 1'h0;
    end
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        ssN = 1'h0;
        for (int i = 7; i >= 0; i--)
        begin
            mosi = tx[i];
            #40 sck = 1'h1;
            rx[i] = miso;
            #40 sck = 1'h0;
        end
        #40 mosi = ~mosi; // Released line keeps no value
        ssN = 1'h1;
    endtask
endmodule

// file: tb/spimux_top_tb_top.sv
/*
 Bench for spimux_top: port C traffic, slave frames, master shifting, reset.
 Assumes the external master model and the bound checker.
*/
`timescale 1ns/10ps
module spimux_top_tb_top;
    logic mclk = 1'h0, rst = 1'h1, misoFuncEnable = 1'h0, mosiFuncEnable = 1'h0;
    logic masterMode = 1'h0, wiredOrSelect = 1'h0, masterClock = 1'h0;
    logic coreLoad = 1'h0, coreTxBit = 1'h0;
    logic [1:0] portCOut = 2'h0, portCDir = 2'h0, ext = 2'h3, portCIn;
    logic misoOut, misoOe, mosiOut, mosiOe, coreRxBit, coreRxStrobe, coreTxTake;
    logic sck, ssN, pMosi, slaveSel;
    logic [31:0] seed = 32'hB96E;
    logic txQ[$], expQ[$];
    int err_total = 0, checked = 0;
    wire misoPin = misoOe ? misoOut : ext[0];
    wire mosiPin = mosiOe ? mosiOut : (ssN ? ext[1] : pMosi);
    spimux_top i_spimux_top (.*, .port0MasterInSlaveOutIn(misoPin),
        .port0MasterOutSlaveInIn(mosiPin), .port0SerialClockIn(sck), .port0SlaveSelectN(ssN),
        .port0MasterInSlaveOutOut(misoOut), .port0MasterInSlaveOutOe(misoOe),
        .port0MasterOutSlaveInOut(mosiOut), .port0MasterOutSlaveInOe(mosiOe),
        .slaveSelected(slaveSel));
    spimux_ext_master i_spimux_ext_master (.sck(sck), .ssN(ssN), .mosi(pMosi), .miso(misoPin));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic load(input logic [7:0] b);
        @(posedge mclk);
        coreTxBit <= b[7];
        coreLoad <= 1'h1;
        @(posedge mclk);
        coreLoad <= 1'h0;
        coreTxBit <= b[6];
        txQ = {};
        for (int i = 5; i >= 0; i--)
            txQ.push_back(b[i]);
    endtask
    initial
        forever #2.5 mclk = ~mclk;
    initial
    begin
        #50000;
        err_total++;
        summarize();
    end
    // Core side model: feeds next bit on take, compares each received bit
    always @(posedge mclk)
    begin
        if (coreTxTake === 1'h1 && txQ.size() > 0)
            coreTxBit <= txQ.pop_front();
        if (coreRxStrobe === 1'h1 && expQ.size() > 0)
            check("rx bit", {7'h0, coreRxBit}, {7'h0, expQ.pop_front()});
        if (coreRxStrobe === 1'h1 && masterMode === 1'h0)
            check("selected", {7'h0, slaveSel}, 8'h01);
    end
    initial
    begin
        logic [7:0] rx, pins;
        repeat (10) @(negedge mclk);
        check("reset pins", {4'h0, misoOe, mosiOe, portCIn}, 8'h00);
        @(posedge mclk);
        rst <= 1'h0;
        repeat (40)
        begin
            @(posedge mclk);
            seed = lfsr(seed);
            portCOut <= seed[1:0];
            portCDir <= seed[3:2];
            ext <= seed[5:4];
            repeat (5) @(negedge mclk);
            pins = {4'h0, mosiOe, misoOe, mosiOe & mosiOut, misoOe & misoOut};
            check("gpio out", pins, {4'h0, portCDir, portCDir & portCOut});
            pins = {6'h0, portCDir & portCOut | ~portCDir & ext};
            check("gpio in", {6'h0, portCIn}, pins);
        end
        @(posedge mclk);
        misoFuncEnable <= 1'h1;
        mosiFuncEnable <= 1'h1;
        ext <= 2'h3; // Pull-ups on released data lines
        for (int w = 0; w < 2; w++)
        begin
            @(posedge mclk);
            wiredOrSelect <= w[0];
            seed = lfsr(seed);
            load(seed[7:0]);
            for (int i = 7; i >= 0; i--)
                expQ.push_back(seed[8 + i]);
            repeat (6) @(negedge mclk);
            check("idle miso oe", {7'h0, misoOe}, 8'h00);
            #1.3 i_spimux_ext_master.frame(seed[15:8], rx);
            check("miso byte", rx, seed[7:0]);
            repeat (6) @(negedge mclk);
            check("released miso", {6'h0, misoOe, slaveSel}, 8'h00);
        end
        @(posedge mclk);
        masterMode <= 1'h1;
        wiredOrSelect <= 1'h0;
        seed = lfsr(seed);
        load(seed[7:0]);
        for (int i = 7; i >= 0; i--)
        begin
            ext <= {1'h1, seed[8 + i]};
            expQ.push_back(seed[8 + i]);
            repeat (8) @(posedge mclk);
            masterClock <= 1'h1;
            @(negedge mclk);
            check("mosi at rise", {6'h0, mosiOe, mosiOut}, {7'h1, seed[i]});
            repeat (8) @(posedge mclk);
            masterClock <= 1'h0;
        end
        check("rx left", 8'(expQ.size()), 8'h00);
        rst <= 1'h1;
        repeat (3) @(negedge mclk);
        check("second reset", {6'h0, misoOe, mosiOe}, 8'h00);
        @(posedge mclk);
        rst <= 1'h0;
        repeat (3) @(negedge mclk);
        check("after release", {6'h0, mosiOe, mosiOut}, 8'h02);
        summarize();
    end
endmodule
